/* hdl/p6m_pkg.sv */
// Purpose: shared constants for the port six pin multiplexer
// Assumes: APB registers, one aligned 32-bit word each, data in bits 7:0
// Notes:   wait pair code for external wait is a named constant
package p6m_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_DATA    = 8'h00;
    localparam logic [7:0] OFS_DIR     = 8'h04;
    localparam logic [7:0] OFS_PULLUP  = 8'h08;
    localparam logic [7:0] OFS_MODE    = 8'h0C;
    localparam logic [7:0] OFS_WAIT1   = 8'h10;
    localparam logic [7:0] OFS_WAIT2   = 8'h14;
    localparam logic [7:0] OFS_HOLD    = 8'h18;
    localparam logic [7:0] OFS_REFRESH = 8'h1C;
    // Field positions
    localparam int PULLUP_BIT  = 6;
    localparam int HOLD_BIT    = 0;
    localparam int REFRESH_BIT = 0;
    localparam int WAIT_PAIRS  = 4;
    // Reset values
    localparam logic [7:0] DIR_RST   = 8'hFF;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [3:0] MODE_RST  = 4'h0;
    localparam logic [7:0] BYTE_RST  = 8'h00;
    // Extension mode codes
    localparam logic [3:0] MODE_STB_LO = 4'h4;
    localparam logic [3:0] MODE_STB_HI = 4'h7;
    localparam logic [3:0] MODE_ADDR2  = 4'h8;
    localparam logic [3:0] MODE_ADDR4  = 4'h9;
    localparam logic [1:0] WAIT_EXT    = 2'h3;
    // Reduced variant: strobe pins drive high from reset
    localparam logic [7:0] RED_RST_OUT = 8'h30;
    localparam logic [7:0] RED_LOW_MASK = 8'h0F;

    // Any of the eight wait pairs asks for the external wait pin
    function automatic logic p6m_any_ext_wait(input logic [7:0] w1,
                                              input logic [7:0] w2);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < WAIT_PAIRS; i++) begin
            hit = hit | (w1[2*i +: 2] == WAIT_EXT) | (w2[2*i +: 2] == WAIT_EXT);
        end
        return hit;
    endfunction
endpackage

/* hdl/p6m_ctl_if.sv */
// Purpose: carries configuration and bus control into the pin decoder
// Assumes: one clock domain, all signals from registers or core logic
// Notes:   decoder is purely combinational
`timescale 1ns/1ps
interface p6m_ctl_if;
    logic [3:0] mode;
    logic [7:0] wait_one;
    logic [7:0] wait_two;
    logic       hold_en;
    logic       refresh_en;
    logic [3:0] addr_hi;
    logic       rd_n;
    logic       wr_n;
    logic       hold_ack;
    logic       refresh_pulse;
    logic [7:0] claim;
    logic [7:0] ctl_val;
    logic [7:0] ctl_oe;
    logic       wait_sel;
    logic       hold_sel;
    modport src (output mode, wait_one, wait_two, hold_en, refresh_en, addr_hi,
                 rd_n, wr_n, hold_ack, refresh_pulse,
                 input claim, ctl_val, ctl_oe, wait_sel, hold_sel);
    modport dec (input mode, wait_one, wait_two, hold_en, refresh_en, addr_hi,
                 rd_n, wr_n, hold_ack, refresh_pulse,
                 output claim, ctl_val, ctl_oe, wait_sel, hold_sel);
endinterface

/* hdl/p6m_sync.sv */
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs are asynchronous to core_clk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module p6m_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // Two flops against metastability
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* hdl/p6m_decode.sv */
// Purpose: decides which pins a control function claims and their drive
// Assumes: configuration is stable register state
// Notes:   combinational; top registers every result
`timescale 1ns/1ps
module p6m_decode #(
    parameter bit REDUCED = 1'b0
) (
    p6m_ctl_if.dec ctl
);
    logic addr2;
    logic addr4;
    logic strobe;

    // Mode field groups pins two at a time
    assign addr2  = (ctl.mode == p6m_pkg::MODE_ADDR2) || (ctl.mode == p6m_pkg::MODE_ADDR4);
    assign addr4  = (ctl.mode == p6m_pkg::MODE_ADDR4);
    assign strobe = REDUCED || addr2 ||
                    ((ctl.mode >= p6m_pkg::MODE_STB_LO) && (ctl.mode <= p6m_pkg::MODE_STB_HI));

    // Pin six input functions; hold shares the pin with wait
    assign ctl.wait_sel = p6m_pkg::p6m_any_ext_wait(ctl.wait_one, ctl.wait_two);
    assign ctl.hold_sel = ctl.hold_en;

    always_comb begin
        ctl.claim   = 8'h00;
        ctl.ctl_val = 8'h00;
        ctl.ctl_oe  = 8'h00;
        // Upper address outputs
        if (addr2) begin
            ctl.claim[1:0]   = 2'h3;
            ctl.ctl_val[1:0] = ctl.addr_hi[1:0];
            ctl.ctl_oe[1:0]  = 2'h3;
        end
        if (addr4) begin
            ctl.claim[3:2]   = 2'h3;
            ctl.ctl_val[3:2] = ctl.addr_hi[3:2];
            ctl.ctl_oe[3:2]  = 2'h3;
        end
        // Strobes, kept in address modes as well
        if (strobe) begin
            ctl.claim[5:4]   = 2'h3;
            ctl.ctl_val[4]   = ctl.rd_n;
            ctl.ctl_val[5]   = ctl.wr_n;
            ctl.ctl_oe[5:4]  = 2'h3;
        end
        // Wait or hold request: input, driver off
        if (ctl.wait_sel || ctl.hold_sel) begin
            ctl.claim[6] = 1'b1;
        end
        // Hold acknowledge wins pin seven over refresh
        if (ctl.hold_en) begin
            ctl.claim[7]   = 1'b1;
            ctl.ctl_val[7] = ctl.hold_ack;
            ctl.ctl_oe[7]  = 1'b1;
        end else if (ctl.refresh_en) begin
            ctl.claim[7]   = 1'b1;
            ctl.ctl_val[7] = ctl.refresh_pulse;
            ctl.ctl_oe[7]  = 1'b1;
        end
    end
endmodule

/* hdl/p6m_top.sv */
// Purpose: port six pin multiplexer with APB register file
// Assumes: core bus controller supplies strobes, upper address, hold
//          acknowledge and refresh pulses on core_clk
// Notes:   every pin drive passes one flop, so pins trail core by a cycle
// Notes on behaviour
// - eight pins, latch each, pull-ups
// - full variant resets to inputs, drivers off
// - reduced: 0-3 outputs, 4-5 strobes, 6-7 bidirectional
// - reduced reset: 0-3 undriven, 4-5 high
// - reduced 0-3 float in reset, then low
// - mode field claims pins in pairs
// - codes eight and nine give upper address
// - upper address bits sixteen to nineteen driven
// - pin four carries read strobe
// - pin five carries write strobe
// - pin six is wait input when selected
// - hold enable: pin six request, seven acknowledge
// - refresh enable puts refresh pulses on seven unless hold enable is set
// - free pins follow direction register bits
// - pull-up only when enabled and input
// - input pins store latch, read pin level
// - claimed pins neither written nor read
`timescale 1ns/1ps
module p6m_top #(
    parameter bit REDUCED = 1'b0,
    parameter int ADDR_W  = 8
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata_q,
    output logic                   pready_q,
    output logic                   pslverr_q,
    // Core bus controller
    input  wire logic [3:0]        core_addr_hi,
    input  wire logic              core_rd_n,
    input  wire logic              core_wr_n,
    input  wire logic              core_hold_ack,
    input  wire logic              core_refresh_pulse,
    output logic                   wait_req_q,
    output logic                   hold_req_q,
    // Pins
    input  wire logic [7:0]        pin_in,
    output logic      [7:0]        pin_out_q,
    output logic      [7:0]        pin_oe_q,
    output logic      [7:0]        pullup_en_q
);
    typedef enum logic [1:0] {
        P6M_IDLE = 2'b00,
        P6M_WAIT = 2'b01,
        P6M_DONE = 2'b11
    } p6m_apb_st_t;

    // Reset drive depends on variant only, so it stays a constant
    localparam logic [7:0] OUT_RST = REDUCED ? p6m_pkg::RED_RST_OUT : 8'h00;
    localparam logic [7:0] OE_RST  = REDUCED ? p6m_pkg::RED_RST_OUT : 8'h00;
    localparam logic [7:0] OUT_ONLY = REDUCED ? p6m_pkg::RED_LOW_MASK : 8'h00;
    localparam logic [7:0] NO_PULL  = REDUCED ? p6m_pkg::RED_LOW_MASK : 8'h00;

    p6m_apb_st_t st_q;
    p6m_apb_st_t st_d;
    logic [7:0]  latch_q;
    logic [7:0]  dir_q;
    logic [7:0]  pullup_q;
    logic [3:0]  mode_q;
    logic [7:0]  wait1_q;
    logic [7:0]  wait2_q;
    logic        hold_q;
    logic        refresh_q;
    logic [7:0]  pin_sync;
    logic [7:0]  is_input;
    logic [7:0]  oe_d;
    logic [7:0]  out_d;
    logic [7:0]  pull_d;
    logic [7:0]  port_rd;
    logic [7:0]  rd_byte;
    logic        rd_ok;
    logic        wr_fire;
    logic        wr_lane;
    logic [7:0]  wbyte;

    p6m_ctl_if ctl ();

    // Offset decode, shared by read and write
    function automatic logic p6m_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // Pin levels come from outside and are synchronised first
    p6m_sync #(
        .WIDTH    (8)
    ) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // Configuration and core control into the decoder
    assign ctl.mode          = mode_q;
    assign ctl.wait_one      = wait1_q;
    assign ctl.wait_two      = wait2_q;
    assign ctl.hold_en       = hold_q;
    assign ctl.refresh_en    = refresh_q;
    assign ctl.addr_hi       = core_addr_hi;
    assign ctl.rd_n          = core_rd_n;
    assign ctl.wr_n          = core_wr_n;
    assign ctl.hold_ack      = core_hold_ack;
    assign ctl.refresh_pulse = core_refresh_pulse;

    p6m_decode #(
        .REDUCED (REDUCED)
    ) u_decode (
        .ctl     (ctl.dec)
    );

    // APB sequencing: one wait cycle, answer on the second access cycle
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            P6M_IDLE: begin
                if (psel && !penable) begin
                    st_d = P6M_WAIT;
                end
            end
            P6M_WAIT: begin
                if (psel && penable) begin
                    st_d = P6M_DONE;
                end
            end
            P6M_DONE: begin
                st_d = P6M_IDLE;
            end
            default: begin
                st_d = P6M_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= P6M_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Write commits on the completing edge only
    assign wr_fire = psel && penable && pready_q && pwrite;
    assign wr_lane = pstrb[0];
    assign wbyte   = pwdata[7:0];

    // Read mux and unmapped detection
    always_comb begin
        rd_ok   = 1'b1;
        rd_byte = 8'h00;
        if (p6m_hit(paddr, p6m_pkg::OFS_DATA)) begin
            rd_byte = port_rd;
        end else if (p6m_hit(paddr, p6m_pkg::OFS_DIR)) begin
            rd_byte = dir_q;
        end else if (p6m_hit(paddr, p6m_pkg::OFS_PULLUP)) begin
            rd_byte = pullup_q;
        end else if (p6m_hit(paddr, p6m_pkg::OFS_MODE)) begin
            rd_byte = {4'h0, mode_q};
        end else if (p6m_hit(paddr, p6m_pkg::OFS_WAIT1)) begin
            rd_byte = wait1_q;
        end else if (p6m_hit(paddr, p6m_pkg::OFS_WAIT2)) begin
            rd_byte = wait2_q;
        end else if (p6m_hit(paddr, p6m_pkg::OFS_HOLD)) begin
            rd_byte[p6m_pkg::HOLD_BIT] = hold_q;
        end else if (p6m_hit(paddr, p6m_pkg::OFS_REFRESH)) begin
            rd_byte[p6m_pkg::REFRESH_BIT] = refresh_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Bus answer flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= (st_d == P6M_DONE);
            if (st_d == P6M_DONE) begin
                pslverr_q <= !rd_ok;
                prdata_q  <= (!pwrite && rd_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end else begin
                pslverr_q <= 1'b0;
                prdata_q  <= 32'h0000_0000;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_q     <= p6m_pkg::DIR_RST;
            pullup_q  <= p6m_pkg::BYTE_RST;
            mode_q    <= p6m_pkg::MODE_RST;
            wait1_q   <= p6m_pkg::BYTE_RST;
            wait2_q   <= p6m_pkg::BYTE_RST;
            hold_q    <= 1'b0;
            refresh_q <= 1'b0;
        end else if (wr_fire && wr_lane && rd_ok) begin
            if (p6m_hit(paddr, p6m_pkg::OFS_DIR)) begin
                dir_q <= wbyte;
            end
            if (p6m_hit(paddr, p6m_pkg::OFS_PULLUP)) begin
                pullup_q <= wbyte;
            end
            if (p6m_hit(paddr, p6m_pkg::OFS_MODE)) begin
                mode_q <= wbyte[3:0];
            end
            if (p6m_hit(paddr, p6m_pkg::OFS_WAIT1)) begin
                wait1_q <= wbyte;
            end
            if (p6m_hit(paddr, p6m_pkg::OFS_WAIT2)) begin
                wait2_q <= wbyte;
            end
            if (p6m_hit(paddr, p6m_pkg::OFS_HOLD)) begin
                hold_q <= wbyte[p6m_pkg::HOLD_BIT];
            end
            if (p6m_hit(paddr, p6m_pkg::OFS_REFRESH)) begin
                refresh_q <= wbyte[p6m_pkg::REFRESH_BIT];
            end
        end
    end

    // Output latch; claimed bits keep their old value
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_q <= p6m_pkg::LATCH_RST;
        end else if (wr_fire && wr_lane && p6m_hit(paddr, p6m_pkg::OFS_DATA)) begin
            latch_q <= (wbyte & ~ctl.claim) | (latch_q & ctl.claim);
        end
    end

    // Per-pin drive, pull-up and read-back
    for (genvar n = 0; n < 8; n++) begin : g_pin
        // Reduced low pins are output-only whatever direction says
        assign is_input[n] = dir_q[n] && !OUT_ONLY[n];
        assign oe_d[n]     = ctl.claim[n] ? ctl.ctl_oe[n] : !is_input[n];
        assign out_d[n]    = ctl.claim[n] ? ctl.ctl_val[n] : latch_q[n];
        // Pull-up only on a free input, or a claimed input such as wait
        assign pull_d[n]   = pullup_q[p6m_pkg::PULLUP_BIT] && !NO_PULL[n] &&
                             (ctl.claim[n] ? !ctl.ctl_oe[n] : is_input[n]);
        // Claimed pins read as zero; inputs read the pin
        assign port_rd[n]  = ctl.claim[n] ? 1'b0 :
                             (is_input[n] ? pin_sync[n] : latch_q[n]);
    end

    // Pin flops; reset values give the variant's reset levels
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_q   <= OUT_RST;
            pin_oe_q    <= OE_RST;
            pullup_en_q <= 8'h00;
        end else begin
            pin_out_q   <= out_d;
            pin_oe_q    <= oe_d;
            pullup_en_q <= pull_d;
        end
    end

    // Wait and hold request forwarded to the core
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_req_q <= 1'b0;
            hold_req_q <= 1'b0;
        end else begin
            wait_req_q <= ctl.wait_sel && !ctl.hold_sel && !pin_sync[6];
            hold_req_q <= ctl.hold_sel && !pin_sync[6];
        end
    end
endmodule

/* bench/p6m_props.sv */
// Purpose: concurrent checks on the port six pin multiplexer ports
// Assumes: full variant, APB writes land at the edge where pready_q is seen
// Notes:   config shadow ties pin relations to their cause
`timescale 1ns/1ps
module p6m_props #(
    parameter int ADDR_W = 8
) (
    input wire logic              core_clk,
    input wire logic              rst_b,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata_q,
    input wire logic              pready_q,
    input wire logic              pslverr_q,
    input wire logic [3:0]        core_addr_hi,
    input wire logic              core_rd_n,
    input wire logic              core_wr_n,
    input wire logic              core_hold_ack,
    input wire logic              core_refresh_pulse,
    input wire logic              wait_req_q,
    input wire logic              hold_req_q,
    input wire logic [7:0]        pin_in,
    input wire logic [7:0]        pin_out_q,
    input wire logic [7:0]        pin_oe_q,
    input wire logic [7:0]        pullup_en_q
);
    logic [7:0] dir_q, lat_q, w1_q, w2_q;
    logic [3:0] mode_q;
    logic       pu_q, hold_q, rf_q, wsel, wr_ok, rd_dat;
    assign wr_ok  = pready_q && psel && penable && pwrite && pstrb[0] && !pslverr_q;
    assign rd_dat = pready_q && !pwrite && paddr[7:0] == p6m_pkg::OFS_DATA;
    // Config shadow; latch only tracked in port modes, strobe modes drop writes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_q  <= p6m_pkg::DIR_RST;
            lat_q  <= p6m_pkg::LATCH_RST;
            w1_q   <= p6m_pkg::BYTE_RST;
            w2_q   <= p6m_pkg::BYTE_RST;
            mode_q <= p6m_pkg::MODE_RST;
            pu_q   <= 1'b0;
            hold_q <= 1'b0;
            rf_q   <= 1'b0;
        end else if (wr_ok) begin
            case (paddr[7:0])
                p6m_pkg::OFS_DATA:    lat_q  <= (mode_q >= 4'h4 && mode_q <= 4'h9) ? lat_q : pwdata[7:0];
                p6m_pkg::OFS_DIR:     dir_q  <= pwdata[7:0];
                p6m_pkg::OFS_PULLUP:  pu_q   <= pwdata[p6m_pkg::PULLUP_BIT];
                p6m_pkg::OFS_MODE:    mode_q <= pwdata[3:0];
                p6m_pkg::OFS_WAIT1:   w1_q   <= pwdata[7:0];
                p6m_pkg::OFS_WAIT2:   w2_q   <= pwdata[7:0];
                p6m_pkg::OFS_HOLD:    hold_q <= pwdata[p6m_pkg::HOLD_BIT];
                p6m_pkg::OFS_REFRESH: rf_q   <= pwdata[p6m_pkg::REFRESH_BIT];
                default:              ;
            endcase
        end
    end
    // Any pair asking for the external wait pin
    always_comb begin
        wsel = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wsel = wsel | (w1_q[2*i +: 2] == 2'h3) | (w2_q[2*i +: 2] == 2'h3);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_reset_hiz; disable iff (1'b0) !rst_b |-> pin_oe_q == 8'h00 && pullup_en_q == 8'h00; endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("reset drive");
    property p_port; $past(mode_q) == 4'h0 |-> pin_oe_q[5:0] == ~$past(dir_q[5:0]) && (pin_out_q[5:0] & pin_oe_q[5:0]) == ($past(lat_q[5:0]) & pin_oe_q[5:0]); endproperty
    a_port: assert property (p_port) else $error("port drive");
    property p_addr4; $past(mode_q) == 4'h9 |-> pin_oe_q[3:0] == 4'hF && pin_out_q[3:0] == $past(core_addr_hi); endproperty
    a_addr4: assert property (p_addr4) else $error("addr4");
    property p_addr2; $past(mode_q) == 4'h8 |-> pin_out_q[1:0] == $past(core_addr_hi[1:0]) && pin_oe_q[3:0] == {~$past(dir_q[3:2]), 2'b11}; endproperty
    a_addr2: assert property (p_addr2) else $error("addr2");
    property p_strobe; $past(mode_q) >= 4'h4 && $past(mode_q) <= 4'h9 |-> pin_oe_q[5:4] == 2'b11 && pin_out_q[5:4] == {$past(core_wr_n), $past(core_rd_n)}; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe");
    property p_pull; (pullup_en_q & (pin_oe_q | {8{!$past(pu_q)}})) == 8'h00; endproperty
    a_pull: assert property (p_pull) else $error("pullup");
    property p_hold_pin; $past(hold_q) |-> pin_oe_q[7:6] == 2'b10 && pin_out_q[7] == $past(core_hold_ack); endproperty
    a_hold_pin: assert property (p_hold_pin) else $error("hold pins");
    property p_refresh; $past(rf_q && !hold_q) |-> pin_oe_q[7] && pin_out_q[7] == $past(core_refresh_pulse); endproperty
    a_refresh: assert property (p_refresh) else $error("refresh");
    property p_holdreq; (hold_q && !pin_in[6])[*4] |=> hold_req_q; endproperty
    a_holdreq: assert property (p_holdreq) else $error("hold req");
    property p_waitreq; (wsel && !hold_q && !pin_in[6])[*4] |=> wait_req_q; endproperty
    a_waitreq: assert property (p_waitreq) else $error("wait req");
    property p_noreq; (!hold_q)[*2] |-> !hold_req_q; endproperty
    a_noreq: assert property (p_noreq) else $error("stray hold req");
    property p_claim_rd; rd_dat && $past(mode_q) == 4'h9 |-> prdata_q[5:0] == 6'h00; endproperty
    a_claim_rd: assert property (p_claim_rd) else $error("claimed read");
    property p_answer; psel && penable && !pready_q |=> pready_q ##1 !pready_q; endproperty
    a_answer: assert property (p_answer) else $error("APB answer");
    c_addr4: cover property ($past(mode_q) == 4'h9);
    c_hold: cover property (hold_req_q);
    c_wait: cover property (wait_req_q);
    c_err: cover property (pslverr_q);
endmodule
bind p6m_top p6m_props #(.ADDR_W(ADDR_W)) p6m_props_i (.*);

/* bench/p6m_ext_model.sv */
// Purpose: far side of port six, memory and bus master pin drivers
// Assumes: bench chooses which pins the outside world drives
// Notes:   bare undriven lines toggle
`timescale 1ns/1ps
module p6m_ext_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] pin_out_q,
    input  wire logic [7:0] pin_oe_q,
    input  wire logic [7:0] pullup_en_q,
    input  wire logic [7:0] ext_oe,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    logic [7:0] float_q = 8'h5A;
    // Floating level changes so a stale value never passes as a drive
    always @(posedge core_clk) float_q <= ~float_q;
    // Wire resolution: device, then outside party, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_q[i]) pin_in[i] = pin_out_q[i];
            else if (ext_oe[i]) pin_in[i] = ext_val[i];
            else if (pullup_en_q[i]) pin_in[i] = 1'b1;
            else pin_in[i] = float_q[i];
        end
    end
endmodule

/* bench/tb_top.sv */
// Purpose: self-checking bench for the port six pin multiplexer
// Assumes: full variant, APB answer after one wait cycle
// Notes:   random phase leaves the latch alone
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, ext_oe = 8'h00, ext_val = 8'h00, d, r, a;
    logic [31:0] pwdata = 32'h0, prdata_q, rdat;
    logic [3:0] core_addr_hi = 4'h0;
    logic core_rd_n = 1'b1, core_wr_n = 1'b1, core_hold_ack = 1'b0, core_refresh_pulse = 1'b0;
    logic pready_q, pslverr_q, wait_req_q, hold_req_q, err, core_rand = 1'b0;
    logic [7:0] pin_in, pin_out_q, pin_oe_q, pullup_en_q;
    logic [15:0] seed = 16'hC851, rseed = 16'hC851;
    logic [5:0] cl;
    int mismatches = 0, checked = 0;
    always #2.5 core_clk = ~core_clk;
    p6m_top #(.REDUCED(1'b0), .ADDR_W(8)) p6m_top_i (.*, .pstrb(4'hF));
    p6m_ext_model p6m_ext_model_i (.*);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction
    // Pins 0 to 5 taken by the extension mode code
    function automatic logic [5:0] exp_claim(input int m);
        if (m == 9) return 6'h3F;
        if (m == 8) return 6'h33;
        if (m >= 4) return 6'h30;
        return 6'h00;
    endfunction
    task automatic end_of_test();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; request held until pready_q is sampled high
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready_q !== 1'b1 && n < 20);
        rdat = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            end_of_test();
        end
    endtask
    task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(nm, exp, rdat);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Free-running core bus activity for the random phase
    always @(posedge core_clk) begin
        if (core_rand) begin
            rseed <= lfsr(rseed);
            {core_refresh_pulse, core_hold_ack, core_wr_n, core_rd_n, core_addr_hi} <= rseed[7:0];
        end
    end
    initial begin
        tick(11);
        chk("oe_in_reset", 32'h0, pin_oe_q);
        @(posedge core_clk);
        rst_b <= 1'b1;
        tick(2);
        chk("oe_after_reset", 32'h0, pin_oe_q);
        rdc("dir_reset", p6m_pkg::OFS_DIR, 32'h000000FF);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", 32'h1, err);
        apb(1'b1, p6m_pkg::OFS_PULLUP, 32'h40);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            {d, r} = seed;
            apb(1'b1, p6m_pkg::OFS_DATA, r);
            apb(1'b1, p6m_pkg::OFS_DIR, d);
            tick(5);
            chk("port_oe", {~d}, pin_oe_q);
            chk("port_out", {r & ~d}, {pin_out_q & ~d});
            chk("pullup", d, pullup_en_q);
            rdc("port_read", p6m_pkg::OFS_DATA, {r | d});
        end
        for (int m = 0; m < 10; m++) begin
            seed = lfsr(seed);
            @(posedge core_clk);
            {core_wr_n, core_rd_n, core_addr_hi} <= seed[5:0];
            apb(1'b1, p6m_pkg::OFS_MODE, m);
            tick(4);
            cl = exp_claim(m);
            chk("mode_oe", {cl | ~d[5:0]}, pin_oe_q[5:0]);
            chk("mode_out", {(cl & seed[5:0]) | (~cl & ~d[5:0] & r[5:0])},
                {pin_out_q[5:0] & pin_oe_q[5:0]});
            rdc("mode_read", p6m_pkg::OFS_DATA, {r[7:6] | d[7:6], ~cl & (r[5:0] | d[5:0])});
        end
        apb(1'b1, p6m_pkg::OFS_DATA, {~r});
        apb(1'b1, p6m_pkg::OFS_MODE, 32'h0);
        tick(4);
        chk("latch_kept", {r[5:0] & ~d[5:0]}, {pin_out_q[5:0] & ~d[5:0]});
        d = d & 8'hBF;
        apb(1'b1, p6m_pkg::OFS_DIR, d);
        apb(1'b1, p6m_pkg::OFS_WAIT2, 32'hC0);
        @(posedge core_clk);
        ext_oe <= 8'h40;
        tick(6);
        chk("wait_req", 32'h1, wait_req_q);
        chk("wait_pin_in", 32'h0, pin_oe_q[6]);
        @(posedge core_clk);
        ext_val <= 8'h40;
        tick(6);
        chk("wait_release", 32'h0, wait_req_q);
        @(posedge core_clk);
        ext_val <= 8'h00;
        core_hold_ack <= 1'b1;
        apb(1'b1, p6m_pkg::OFS_REFRESH, 32'h1);
        apb(1'b1, p6m_pkg::OFS_HOLD, 32'h1);
        tick(6);
        chk("hold_req", 32'h2, {hold_req_q, wait_req_q});
        chk("hold_ack_pin", 32'h3, {pin_oe_q[7], pin_out_q[7]});
        @(posedge core_clk);
        core_hold_ack <= 1'b0;
        tick(2);
        chk("hold_ack_low", 32'h2, {pin_oe_q[7], pin_out_q[7]});
        apb(1'b1, p6m_pkg::OFS_HOLD, 32'h0);
        @(posedge core_clk);
        core_refresh_pulse <= 1'b1;
        tick(2);
        chk("refresh_pin", 32'h6, {pin_oe_q[7], pin_out_q[7], hold_req_q});
        @(posedge core_clk);
        ext_oe <= 8'h00;
        core_rand <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            seed = lfsr(seed);
            a = (seed[2:0] == 3'h0) ? 8'h20 : {3'h0, seed[2:0], 2'h0};
            apb(1'b1, a, seed[15:8]);
            chk("rand_err", {a == 8'h20}, err);
        end
        end_of_test();
    end
endmodule
